//--- shared/timer2_regs.vh
/*
  Constants of the 16-bit capture/reload timer: register indices, field
  positions, reset values and tick dividers.
  Assumes inclusion by a design file that reads registers over APB, where
  the byte address of a register is four times its index.
*/
`ifndef TIMER2_REGS_VH
`define TIMER2_REGS_VH

// Register indices
`define IDX_TIMER_CONTROL       8'hC8
`define IDX_TIMER_MODE_CONTROL  8'hC9
`define IDX_RELOAD_CAPTURE_LOW  8'hCA
`define IDX_RELOAD_CAPTURE_HIGH 8'hCB
`define IDX_COUNT_LOW_BYTE      8'hCC
`define IDX_COUNT_HIGH_BYTE     8'hCD
`define IDX_TICK_RATE           8'hCE

// Timer control fields
`define BIT_OVERFLOW_FLAG       7
`define BIT_EXTERNAL_FLAG       6
`define BIT_RX_BAUD_SELECT      5
`define BIT_TX_BAUD_SELECT      4
`define BIT_EXTERNAL_ENABLE     3
`define BIT_RUN_CONTROL         2
`define BIT_COUNTER_SELECT      1
`define BIT_CAPTURE_SELECT      0

// Mode control fields
`define BIT_CAPTURE_AUTO_CLEAR  3
`define BIT_CLOCK_OUT_ENABLE    1
`define BIT_DOWN_COUNT_ENABLE   0

// Tick rate field
`define BIT_TICK_RATE_SELECT    0

// Reset values and the all-ones count
`define RST_BYTE                8'h00
`define RST_COUNT               16'h0000
`define COUNT_ALL_ONES          16'hFFFF

// Tick dividers in clocks per tick
`define DIV_SLOW                4'hC
`define DIV_FAST                4'h4
`define DIV_BAUD                4'h2

`endif

//--- core/timer2_capture_reload.v
/*
  16-bit timer/counter with capture, auto-reload, up/down counting,
  baud-tick generation for serial port 0 and a clock output.
  Assumes an APB master on sys_clk and asynchronous pins on the trigger
  and count inputs; the count pin is two-way when used as clock output.
*/
// Chosen here: register access over APB.
`include "timer2_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module timer2_capture_reload #(
  parameter [3:0] DIV_SLOW = `DIV_SLOW,
  parameter [3:0] DIV_FAST = `DIV_FAST
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Pins
  input  wire        trigger_pin,
  input  wire        count_input_pin,
  output reg         count_pin_out,
  output reg         count_pin_oe,
  // Serial port and interrupt
  output reg         rx_baud_tick,
  output reg         tx_baud_tick,
  output reg         timer_irq_req
);

  function hit;
    input [31:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h0) && (addr[9:2] == idx);
    end
  endfunction

  // Register state
  reg [7:0]  control_reg;
  reg [7:0]  mode_reg;
  reg        rate_reg;
  reg [15:0] rcap_reg;
  reg [15:0] count_reg;
  reg [3:0]  prescale_reg;

  // Pin synchronisers and edge history
  reg        trig_s1_reg;
  reg        trig_s2_reg;
  reg        trig_s3_reg;
  reg        cnt_s1_reg;
  reg        cnt_s2_reg;
  reg        cnt_s3_reg;

  // Next values
  reg [7:0]  control_next;
  reg [7:0]  mode_next;
  reg        rate_next;
  reg [15:0] rcap_next;
  reg [15:0] count_next;
  reg [3:0]  prescale_next;
  reg [31:0] rdata_next;

  wire overflow_flag        = control_reg[`BIT_OVERFLOW_FLAG];
  wire external_flag        = control_reg[`BIT_EXTERNAL_FLAG];
  wire rx_baud_select       = control_reg[`BIT_RX_BAUD_SELECT];
  wire tx_baud_select       = control_reg[`BIT_TX_BAUD_SELECT];
  wire external_enable      = control_reg[`BIT_EXTERNAL_ENABLE];
  wire run_control          = control_reg[`BIT_RUN_CONTROL];
  wire counter_timer_select = control_reg[`BIT_COUNTER_SELECT];
  wire capture_reload_select = control_reg[`BIT_CAPTURE_SELECT];
  wire capture_auto_clear   = mode_reg[`BIT_CAPTURE_AUTO_CLEAR];
  wire clock_out_enable     = mode_reg[`BIT_CLOCK_OUT_ENABLE];
  wire down_count_enable    = mode_reg[`BIT_DOWN_COUNT_ENABLE];

  wire baud_mode  = rx_baud_select | tx_baud_select;
  wire trig_fall  = trig_s3_reg & ~trig_s2_reg;
  wire cnt_fall   = cnt_s3_reg & ~cnt_s2_reg;
  wire [3:0] div  = baud_mode ? `DIV_BAUD : (rate_reg ? DIV_FAST : DIV_SLOW);
  wire presc_end  = (prescale_reg >= div - 4'h1);
  wire updown     = down_count_enable & ~capture_reload_select & ~baud_mode;
  wire count_down = updown & ~trig_s2_reg;

  // Bus phases: a write lands at the edge that completes the access
  wire access   = psel & penable;
  wire wr_fire  = access & pready & pwrite;
  wire rd_setup = access & ~pready;
  wire mapped   = hit(paddr, `IDX_TIMER_CONTROL) | hit(paddr, `IDX_TIMER_MODE_CONTROL) |
                  hit(paddr, `IDX_RELOAD_CAPTURE_LOW) | hit(paddr, `IDX_RELOAD_CAPTURE_HIGH) |
                  hit(paddr, `IDX_COUNT_LOW_BYTE) | hit(paddr, `IDX_COUNT_HIGH_BYTE) |
                  hit(paddr, `IDX_TICK_RATE);

  // Counting events
  reg step;
  reg wrap_up;
  reg wrap_down;
  reg ext_event;
  reg ovf_set;
  reg exf_set;
  reg rx_tick_next;
  reg tx_tick_next;
  reg toggle_out;

  always @* begin
    step          = 1'b0;
    wrap_up       = 1'b0;
    wrap_down     = 1'b0;
    ext_event     = 1'b0;
    ovf_set       = 1'b0;
    exf_set       = 1'b0;
    rx_tick_next  = 1'b0;
    tx_tick_next  = 1'b0;
    toggle_out    = 1'b0;
    count_next    = count_reg;
    rcap_next     = rcap_reg;
    prescale_next = prescale_reg;

    // Prescaler runs only while the timer runs
    if (run_control) begin
      if (presc_end)
        prescale_next = 4'h0;
      else
        prescale_next = prescale_reg + 4'h1;
    end else begin
      prescale_next = 4'h0;
    end

    if (baud_mode)
      step = run_control & presc_end;
    else if (counter_timer_select)
      step = run_control & cnt_fall & ~clock_out_enable;
    else
      step = run_control & presc_end;

    if (step) begin
      if (count_down) begin
        if (count_reg == rcap_reg) begin
          wrap_down  = 1'b1;
          count_next = `COUNT_ALL_ONES;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end else if (count_reg == `COUNT_ALL_ONES) begin
        wrap_up = 1'b1;
        if (baud_mode | ~capture_reload_select)
          count_next = rcap_reg;
        else
          count_next = `RST_COUNT;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end

    if (wrap_up | wrap_down) begin
      toggle_out = clock_out_enable;
      if (baud_mode) begin
        rx_tick_next = rx_baud_select;
        tx_tick_next = tx_baud_select;
      end else begin
        ovf_set = 1'b1;
      end
      if (updown)
        exf_set = 1'b1;
    end

    // Trigger pin events, ignored in up/down mode where the pin sets direction
    ext_event = trig_fall & external_enable & ~updown;
    if (ext_event) begin
      exf_set = 1'b1;
      if (!baud_mode) begin
        if (capture_reload_select) begin
          rcap_next = count_reg;
          if (capture_auto_clear)
            count_next = `RST_COUNT;
        end else begin
          count_next = rcap_reg;
        end
      end
    end

    // Software writes to data registers take precedence over hardware
    if (wr_fire && hit(paddr, `IDX_RELOAD_CAPTURE_LOW))
      rcap_next[7:0] = pwdata[7:0];
    if (wr_fire && hit(paddr, `IDX_RELOAD_CAPTURE_HIGH))
      rcap_next[15:8] = pwdata[7:0];
    if (wr_fire && hit(paddr, `IDX_COUNT_LOW_BYTE))
      count_next[7:0] = pwdata[7:0];
    if (wr_fire && hit(paddr, `IDX_COUNT_HIGH_BYTE))
      count_next[15:8] = pwdata[7:0];
  end

  // Control registers; hardware set wins over a software clear
  always @* begin
    control_next = control_reg;
    mode_next    = mode_reg;
    rate_next    = rate_reg;
    if (wr_fire && hit(paddr, `IDX_TIMER_CONTROL))
      control_next = pwdata[7:0];
    if (wr_fire && hit(paddr, `IDX_TIMER_MODE_CONTROL)) begin
      mode_next = `RST_BYTE;
      mode_next[`BIT_CAPTURE_AUTO_CLEAR] = pwdata[`BIT_CAPTURE_AUTO_CLEAR];
      mode_next[`BIT_CLOCK_OUT_ENABLE]   = pwdata[`BIT_CLOCK_OUT_ENABLE];
      mode_next[`BIT_DOWN_COUNT_ENABLE]  = pwdata[`BIT_DOWN_COUNT_ENABLE];
    end
    if (wr_fire && hit(paddr, `IDX_TICK_RATE))
      rate_next = pwdata[`BIT_TICK_RATE_SELECT];
    if (ovf_set)
      control_next[`BIT_OVERFLOW_FLAG] = 1'b1;
    if (exf_set)
      control_next[`BIT_EXTERNAL_FLAG] = 1'b1;
  end

  // Read mux
  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit(paddr, `IDX_TIMER_CONTROL))
      rdata_next[7:0] = control_reg;
    else if (hit(paddr, `IDX_TIMER_MODE_CONTROL))
      rdata_next[7:0] = mode_reg;
    else if (hit(paddr, `IDX_RELOAD_CAPTURE_LOW))
      rdata_next[7:0] = rcap_reg[7:0];
    else if (hit(paddr, `IDX_RELOAD_CAPTURE_HIGH))
      rdata_next[7:0] = rcap_reg[15:8];
    else if (hit(paddr, `IDX_COUNT_LOW_BYTE))
      rdata_next[7:0] = count_reg[7:0];
    else if (hit(paddr, `IDX_COUNT_HIGH_BYTE))
      rdata_next[7:0] = count_reg[15:8];
    else if (hit(paddr, `IDX_TICK_RATE))
      rdata_next[`BIT_TICK_RATE_SELECT] = rate_reg;
  end

  // Synchronisers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_s3_reg <= 1'b1;
      cnt_s1_reg  <= 1'b1;
      cnt_s2_reg  <= 1'b1;
      cnt_s3_reg  <= 1'b1;
    end else begin
      trig_s1_reg <= trigger_pin;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      cnt_s1_reg  <= count_input_pin;
      cnt_s2_reg  <= cnt_s1_reg;
      cnt_s3_reg  <= cnt_s2_reg;
    end
  end

  // State and APB answer
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_reg   <= `RST_BYTE;
      mode_reg      <= `RST_BYTE;
      rate_reg      <= 1'b0;
      rcap_reg      <= `RST_COUNT;
      count_reg     <= `RST_COUNT;
      prescale_reg  <= 4'h0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      count_pin_out <= 1'b0;
      count_pin_oe  <= 1'b0;
      rx_baud_tick  <= 1'b0;
      tx_baud_tick  <= 1'b0;
      timer_irq_req <= 1'b0;
    end else begin
      control_reg   <= control_next;
      mode_reg      <= mode_next;
      rate_reg      <= rate_next;
      rcap_reg      <= rcap_next;
      count_reg     <= count_next;
      prescale_reg  <= prescale_next;
      pready        <= rd_setup;
      pslverr       <= rd_setup & ~mapped;
      if (rd_setup)
        prdata <= rdata_next;
      count_pin_oe  <= clock_out_enable;
      if (!clock_out_enable)
        count_pin_out <= 1'b0;
      else if (toggle_out)
        count_pin_out <= ~count_pin_out;
      rx_baud_tick  <= rx_tick_next;
      tx_baud_tick  <= tx_tick_next;
      timer_irq_req <= control_next[`BIT_OVERFLOW_FLAG] |
                       control_next[`BIT_EXTERNAL_FLAG];
    end
  end

endmodule

`default_nettype wire

//--- verification/timer2_pin_model.sv
/* Far-side pin model: drives the trigger pin and the count input level.
   Assumes sys_clk from the bench; pulses are held several clocks. */
`timescale 1ns/1ns
`default_nettype none
module timer2_pin_model (
  // Clock
  input  wire logic sys_clk,
  // Pins toward the timer
  output var  logic trigger_pin,
  output var  logic count_level
);
  initial trigger_pin = 1'b1;
  initial count_level = 1'b1;
  // Level held for four clocks
  task set_trigger(input logic v);
    begin
      @(posedge sys_clk);
      trigger_pin <= v;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task fall_trigger;
    begin
      set_trigger(1'b0);
      set_trigger(1'b1);
    end
  endtask
  task pulse_count;
    begin
      @(posedge sys_clk);
      count_level <= 1'b0;
      repeat (3) @(posedge sys_clk);
      count_level <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- verification/timer2_capture_reload_props.sv
/* Checker on the timer ports: APB reply timing, error reply, receive tick width.
   Assumes a bind from the bench onto the timer module. */
`timescale 1ns/1ns
`default_nettype none
module timer2_capture_reload_props (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Outputs
  input wire logic        count_pin_oe,
  input wire logic        rx_baud_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_first_access;
    psel && penable && !$past(penable);
  endsequence
  wire mapped_addr = (paddr[31:2] >= 30'hC8) && (paddr[31:2] <= 30'hCE) &&
                     (paddr[1:0] == 2'h0);
  a_ready_after_access: assert property (s_first_access |=> pready)
    else $error("pready not one cycle after access start");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_has_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (pready && !mapped_addr |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && mapped_addr |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_oe_after_write: assert property ($changed(count_pin_oe) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("clock-out enable moved without a write");
  a_rx_tick_space: assert property (rx_baud_tick |=> !rx_baud_tick)
    else $error("baud ticks closer than two clocks");
endmodule
`default_nettype wire

//--- verification/tb.sv
/* Directed bench for the capture/reload timer over APB.
   Assumes the timer, its header, the pin model and the checker. */
`include "timer2_regs.vh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  rd;
  logic [7:0]  keep;
  logic        err;
  logic        level;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          gap;
  wire  [31:0] prdata;
  wire         pready, pslverr, trigger_pin, count_level, count_pin_out, count_pin_oe;
  wire         rx_baud_tick, tx_baud_tick, timer_irq_req;
  wire         count_wire = count_pin_oe ? count_pin_out : count_level;
  timer2_capture_reload u_timer2_capture_reload (.sys_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_pin,
    .count_input_pin(count_wire), .count_pin_out, .count_pin_oe, .rx_baud_tick,
    .tx_baud_tick, .timer_irq_req);
  timer2_pin_model u_timer2_pin_model (.sys_clk, .trigger_pin, .count_level);
  always #5 sys_clk = ~sys_clk;
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) fail_count++;
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask
  task chk(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, e)
  endtask
  // Time between two coincident receive and transmit ticks
  task tick_gap;
    int n;
    begin
      n = 0;
      while ((rx_baud_tick & tx_baud_tick) !== 1'b1 && n < 100) begin
        @(posedge sys_clk);
        n++;
      end
      level = count_pin_out;
      gap = 0;
      do begin @(posedge sys_clk); gap++; end
        while ((rx_baud_tick & tx_baud_tick) !== 1'b1 && gap < 100);
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    chk(`IDX_TIMER_CONTROL, 8'h00);
    apb(1'b0, 8'hC7, 8'h00);
    `CHK(err, 1'b1)
    // Reload on overflow at the fast tick rate
    wr(`IDX_TICK_RATE, 8'h01);
    wr(`IDX_RELOAD_CAPTURE_HIGH, 8'hFF);
    wr(`IDX_RELOAD_CAPTURE_LOW, 8'hF0);
    wr(`IDX_COUNT_HIGH_BYTE, 8'hFF);
    wr(`IDX_COUNT_LOW_BYTE, 8'hFE);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    repeat (30) @(posedge sys_clk);
    chk(`IDX_TIMER_CONTROL, 8'h84);
    wr(`IDX_TIMER_CONTROL, 8'h80);
    `CHK(timer_irq_req, 1'b1)
    chk(`IDX_COUNT_HIGH_BYTE, 8'hFF);
    apb(1'b0, `IDX_COUNT_LOW_BYTE, 8'h00);
    keep = rd;
    repeat (20) @(posedge sys_clk);
    chk(`IDX_COUNT_LOW_BYTE, keep);
    wr(`IDX_TIMER_CONTROL, 8'h01);
    chk(`IDX_TIMER_CONTROL, 8'h01);
    // Trigger ignored, then capture with auto-clear
    u_timer2_pin_model.fall_trigger();
    chk(`IDX_TIMER_CONTROL, 8'h01);
    wr(`IDX_COUNT_HIGH_BYTE, 8'h12);
    wr(`IDX_COUNT_LOW_BYTE, 8'h34);
    wr(`IDX_TIMER_MODE_CONTROL, 8'h08);
    wr(`IDX_TIMER_CONTROL, 8'h09);
    u_timer2_pin_model.fall_trigger();
    `CHK(timer_irq_req, 1'b1)
    chk(`IDX_TIMER_CONTROL, 8'h49);
    chk(`IDX_RELOAD_CAPTURE_LOW, 8'h34);
    chk(`IDX_RELOAD_CAPTURE_HIGH, 8'h12);
    chk(`IDX_COUNT_LOW_BYTE, 8'h00);
    // Reload from the trigger pin
    wr(`IDX_TIMER_MODE_CONTROL, 8'h00);
    wr(`IDX_TIMER_CONTROL, 8'h08);
    u_timer2_pin_model.fall_trigger();
    chk(`IDX_COUNT_LOW_BYTE, 8'h34);
    chk(`IDX_COUNT_HIGH_BYTE, 8'h12);
    // Counting pin edges
    wr(`IDX_COUNT_HIGH_BYTE, 8'h00);
    wr(`IDX_COUNT_LOW_BYTE, 8'h00);
    wr(`IDX_TIMER_CONTROL, 8'h06);
    repeat (3) u_timer2_pin_model.pulse_count();
    chk(`IDX_COUNT_LOW_BYTE, 8'h03);
    // Down counting with the trigger low
    wr(`IDX_RELOAD_CAPTURE_HIGH, 8'h00);
    wr(`IDX_RELOAD_CAPTURE_LOW, 8'h00);
    wr(`IDX_COUNT_LOW_BYTE, 8'h02);
    wr(`IDX_TIMER_MODE_CONTROL, 8'h01);
    u_timer2_pin_model.set_trigger(1'b0);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    repeat (40) @(posedge sys_clk);
    wr(`IDX_TIMER_CONTROL, 8'hC0);
    chk(`IDX_COUNT_HIGH_BYTE, 8'hFF);
    u_timer2_pin_model.set_trigger(1'b1);
    // Baud generation with clock out
    wr(`IDX_TIMER_MODE_CONTROL, 8'h02);
    wr(`IDX_RELOAD_CAPTURE_HIGH, 8'hFF);
    wr(`IDX_RELOAD_CAPTURE_LOW, 8'hFE);
    wr(`IDX_TIMER_CONTROL, 8'h34);
    `CHK(count_pin_oe, 1'b1)
    tick_gap();
    `CHK(gap, 4)
    `CHK(count_pin_out, ~level)
    wr(`IDX_TIMER_CONTROL, 8'h30);
    chk(`IDX_TIMER_CONTROL, 8'h30);
    // Slow tick rate: three ticks of twelve clocks before the stop lands
    wr(`IDX_TIMER_MODE_CONTROL, 8'h00);
    wr(`IDX_TICK_RATE, 8'h00);
    wr(`IDX_COUNT_HIGH_BYTE, 8'h00);
    wr(`IDX_COUNT_LOW_BYTE, 8'h00);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    repeat (40) @(posedge sys_clk);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    chk(`IDX_COUNT_LOW_BYTE, 8'h03);
    print_verdict();
  end
endmodule
bind timer2_capture_reload timer2_capture_reload_props u_props (.sys_clk, .rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .count_pin_oe, .rx_baud_tick);
`default_nettype wire
